// ---- hdl/msc_meas_config.sv ----
// measurement configuration block: four setup registers, decoded gyro and accel
// configuration, output data rate strobes and low-power accel wake strobe
// assumes the host-port front end and the rate divider / gyro filter registers
// sit outside on the same clock, so their signals need no synchroniser
`timescale 1ns/1ps

module msc_meas_config #(
  parameter int unsigned CYC_32K = msc_pkg::CYC_32K,
  parameter int unsigned CYC_8K = msc_pkg::CYC_8K,
  parameter int unsigned CYC_4K = msc_pkg::CYC_4K,
  parameter int unsigned CYC_1K = msc_pkg::CYC_1K,
  parameter int unsigned CYC_WAKE = msc_pkg::CYC_WAKE
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register access from the host-port front end
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rdata_valid_ff,
  // settings held in neighbouring registers
  input wire logic [7:0] rate_divider,
  input wire logic [2:0] gyro_filter_setting,
  // decoded configuration
  output msc_pkg::msc_gyro_cfg_t gyro_cfg_ff,
  output msc_pkg::msc_accel_cfg_t accel_cfg_ff,
  // rate strobes
  output logic gyro_odr_ff,
  output logic accel_odr_ff,
  output logic accel_wake_ff
);

  // ==========================================================================
  // register state
  logic [7:0] gyro_setup_ff;
  logic [7:0] accel_setup_ff;
  logic [7:0] accel_filter_setup_ff;
  logic [7:0] low_power_setup_ff;
  logic [7:0] nxt_gyro_setup;
  logic [7:0] nxt_accel_setup;
  logic [7:0] nxt_accel_filter_setup;
  logic [7:0] nxt_low_power_setup;
  logic [7:0] nxt_rdata;
  logic nxt_rdata_valid;

  // writes keep only the writable bits, reads return masked contents
  always_comb begin
    nxt_gyro_setup = gyro_setup_ff;
    nxt_accel_setup = accel_setup_ff;
    nxt_accel_filter_setup = accel_filter_setup_ff;
    nxt_low_power_setup = low_power_setup_ff;
    if (reg_wr_en) begin
      unique case (reg_addr)
        msc_pkg::ADDR_GYRO_SETUP: begin
          nxt_gyro_setup = reg_wdata & msc_pkg::MASK_GYRO_SETUP;
        end
        msc_pkg::ADDR_ACCEL_SETUP: begin
          nxt_accel_setup = reg_wdata & msc_pkg::MASK_ACCEL_SETUP;
        end
        msc_pkg::ADDR_ACCEL_FILTER_SETUP: begin
          nxt_accel_filter_setup = reg_wdata & msc_pkg::MASK_ACCEL_FILTER_SETUP;
        end
        msc_pkg::ADDR_LOW_POWER_SETUP: begin
          nxt_low_power_setup = reg_wdata & msc_pkg::MASK_LOW_POWER_SETUP;
        end
        default: begin
          nxt_gyro_setup = gyro_setup_ff; // other addresses belong elsewhere
        end
      endcase
    end
    nxt_rdata_valid = reg_rd_en;
    nxt_rdata = 8'h00;
    if (reg_rd_en) begin
      unique case (reg_addr)
        msc_pkg::ADDR_GYRO_SETUP: begin
          nxt_rdata = gyro_setup_ff & msc_pkg::MASK_GYRO_SETUP;
        end
        msc_pkg::ADDR_ACCEL_SETUP: begin
          nxt_rdata = accel_setup_ff & msc_pkg::MASK_ACCEL_SETUP;
        end
        msc_pkg::ADDR_ACCEL_FILTER_SETUP: begin
          nxt_rdata = accel_filter_setup_ff & msc_pkg::MASK_ACCEL_FILTER_SETUP;
        end
        msc_pkg::ADDR_LOW_POWER_SETUP: begin
          nxt_rdata = low_power_setup_ff;
        end
        default: begin
          nxt_rdata = 8'h00; // unmapped reads as zero
        end
      endcase
    end
  end

  // register file; gyro cycling and averaging reset cleared
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gyro_setup_ff <= msc_pkg::RST_GYRO_SETUP;
      accel_setup_ff <= msc_pkg::RST_ACCEL_SETUP;
      accel_filter_setup_ff <= msc_pkg::RST_ACCEL_FILTER_SETUP;
      low_power_setup_ff <= msc_pkg::RST_LOW_POWER_SETUP;
      reg_rdata_ff <= 8'h00;
      reg_rdata_valid_ff <= 1'b0;
    end else begin
      gyro_setup_ff <= nxt_gyro_setup;
      accel_setup_ff <= nxt_accel_setup;
      accel_filter_setup_ff <= nxt_accel_filter_setup;
      low_power_setup_ff <= nxt_low_power_setup;
      reg_rdata_ff <= nxt_rdata;
      reg_rdata_valid_ff <= nxt_rdata_valid;
    end
  end

  // ==========================================================================
  // field extraction
  logic [1:0] gyro_bypass;
  logic gyro_cycle;
  logic [2:0] gyro_avg_depth;
  logic accel_bypass;
  logic [2:0] accel_filt;
  logic [3:0] wake_code;

  assign gyro_bypass = gyro_setup_ff[msc_pkg::GYRO_BYPASS_LSB +: 2];
  assign gyro_cycle = low_power_setup_ff[msc_pkg::GYRO_CYCLE_BIT];
  assign gyro_avg_depth = low_power_setup_ff[msc_pkg::GYRO_AVG_LSB +: 3];
  assign accel_bypass = accel_filter_setup_ff[msc_pkg::ACCEL_BYPASS_BIT];
  assign accel_filt = accel_filter_setup_ff[msc_pkg::ACCEL_FILT_LSB +: 3];
  assign wake_code = low_power_setup_ff[msc_pkg::WAKE_LSB +: 4];

  // ==========================================================================
  // configuration decode
  msc_pkg::msc_gyro_cfg_t nxt_gyro_cfg;
  msc_pkg::msc_accel_cfg_t nxt_accel_cfg;

  // gyro path: bypass wins over low-power averaging, which wins over the filter
  always_comb begin
    nxt_gyro_cfg.selftest = gyro_setup_ff[msc_pkg::SELFTEST_LSB +: 3];
    nxt_gyro_cfg.range = gyro_setup_ff[msc_pkg::RANGE_LSB +: 2];
    nxt_gyro_cfg.lp_cycle = gyro_cycle;
    nxt_gyro_cfg.avg_samples = 8'h01 << gyro_avg_depth;
    nxt_gyro_cfg.filter_setting = 3'h0;
    if (gyro_bypass[0]) begin
      nxt_gyro_cfg.path = msc_pkg::GP_BYPASS_WIDE;
      nxt_gyro_cfg.rate = msc_pkg::RS_32K;
    end else if (gyro_bypass[1]) begin
      nxt_gyro_cfg.path = msc_pkg::GP_BYPASS_NARROW;
      nxt_gyro_cfg.rate = msc_pkg::RS_32K;
    end else if (gyro_cycle) begin
      // normal filter setting not consulted here
      nxt_gyro_cfg.path = msc_pkg::GP_LP_AVERAGE;
      nxt_gyro_cfg.rate = msc_pkg::RS_1K;
    end else begin
      nxt_gyro_cfg.path = msc_pkg::GP_FILTER;
      nxt_gyro_cfg.filter_setting = gyro_filter_setting;
      // settings 0 and 7 run the filter at 8 kHz, the rest at 1 kHz
      if (gyro_filter_setting == 3'h0 || gyro_filter_setting == 3'h7) begin
        nxt_gyro_cfg.rate = msc_pkg::RS_8K;
      end else begin
        nxt_gyro_cfg.rate = msc_pkg::RS_1K;
      end
    end
  end

  // accel: bypass forces 4 kHz regardless of filter setting
  always_comb begin
    nxt_accel_cfg.selftest = accel_setup_ff[msc_pkg::SELFTEST_LSB +: 3];
    nxt_accel_cfg.range = accel_setup_ff[msc_pkg::RANGE_LSB +: 2];
    nxt_accel_cfg.lp_avg_samples =
      6'h04 << accel_filter_setup_ff[msc_pkg::ACCEL_AVG_LSB +: 2];
    nxt_accel_cfg.bypass = accel_bypass;
    if (accel_bypass) begin
      nxt_accel_cfg.rate = msc_pkg::RS_4K;
      nxt_accel_cfg.filter_setting = 3'h0;
    end else begin
      nxt_accel_cfg.rate = msc_pkg::RS_1K;
      nxt_accel_cfg.filter_setting = accel_filt;
    end
    nxt_accel_cfg.wake_code = wake_code;
    nxt_accel_cfg.wake_valid = (wake_code <= msc_pkg::WAKE_CODE_MAX);
  end

  // configuration outputs from flops, so consumers see one clean edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gyro_cfg_ff <= '0;
      accel_cfg_ff <= '0;
    end else begin
      gyro_cfg_ff <= nxt_gyro_cfg;
      accel_cfg_ff <= nxt_accel_cfg;
    end
  end

  // ==========================================================================
  // base rate ticks, one counter per rate
  // separate counters cost flops but keep each rate free of the others' phase
  localparam int NTICK = 5;
  localparam int unsigned TICK_CYC [NTICK] = '{CYC_32K, CYC_8K, CYC_4K, CYC_1K, CYC_WAKE};
  logic [NTICK-1:0] base_tick;

  genvar gi;
  generate
    for (gi = 0; gi < NTICK; gi++) begin : g_tick
      msc_tick_gen #(
        .PERIOD(TICK_CYC[gi])
      ) u_tick (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick_ff(base_tick[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // output data rate selection
  logic gyro_tick;
  logic accel_tick;
  logic [7:0] gyro_div;
  logic [7:0] accel_div;

  // decoded config flops drive the selection, one cycle behind the register
  always_comb begin
    unique case (gyro_cfg_ff.rate)
      msc_pkg::RS_32K: begin
        gyro_tick = base_tick[0];
      end
      msc_pkg::RS_8K: begin
        gyro_tick = base_tick[1];
      end
      msc_pkg::RS_4K: begin
        gyro_tick = base_tick[2];
      end
      msc_pkg::RS_1K: begin
        gyro_tick = base_tick[3];
      end
    endcase
    if (accel_cfg_ff.rate == msc_pkg::RS_4K) begin
      accel_tick = base_tick[2];
    end else begin
      accel_tick = base_tick[3];
    end
    // the divider only thins the 1 kHz outputs, filter or low-power average; fast paths pass undivided
    gyro_div = 8'h00;
    if (gyro_cfg_ff.rate == msc_pkg::RS_1K) begin
      gyro_div = rate_divider;
    end
    accel_div = rate_divider;
    if (accel_cfg_ff.bypass) begin
      accel_div = 8'h00;
    end
  end

  // low-power gyro: host keeps divider/depth pairs legal, no check done here
  msc_rate_div #(
    .W(8)
  ) u_gyro_odr (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(gyro_tick),
    .divide(gyro_div),
    .strobe_ff(gyro_odr_ff)
  );

  msc_rate_div #(
    .W(8)
  ) u_accel_odr (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(accel_tick),
    .divide(accel_div),
    .strobe_ff(accel_odr_ff)
  );

  // ==========================================================================
  // low-power accel wake rate: 500 Hz tick divided by 2^(11 - code)
  logic [10:0] wake_div;
  logic wake_tick;

  // reserved codes stop the wake strobe rather than guess a rate
  always_comb begin
    wake_div = 11'h000;
    wake_tick = 1'b0;
    if (accel_cfg_ff.wake_valid) begin
      // code 0 shifts out of the 11 bits, so the minus one still yields 2047
      wake_div = (11'h001 << (msc_pkg::WAKE_CODE_MAX - accel_cfg_ff.wake_code))
        - 11'h001;
      wake_tick = base_tick[4];
    end
  end

  msc_rate_div #(
    .W(11)
  ) u_wake (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(wake_tick),
    .divide(wake_div),
    .strobe_ff(accel_wake_ff)
  );

endmodule : msc_meas_config

// ---- hdl/msc_pkg.sv ----
// measurement configuration package: register map, field layout, rates, carriers
// assumes a single 250 MHz system clock and a host-port front end on the same clock
//
// Notes on behaviour
// - gyro range bits 4:3 select 500, 1000, 2000 or 4000 dps full scale.
// - gyro bypass field bits 1:0 chooses between filter bypass and low-pass filter.
// - bypass bit0 set gives 32 kHz wide; pattern 10 gives 32 kHz narrow; 00 filters.
// - accel range bits 4:3 select 4, 8, 16 or 32 g full scale.
// - low-power accel averages 4, 8, 16 or 32 samples from bits 5:4.
// - accel bypass bit 3 set skips the filter, 4 kHz output rate.
// - accel bypass clear filters at 1 kHz with bandwidth set by bits 2:0.
// - 1 kHz filter output rate divided by one plus the 8-bit rate divider.
// - bit 7 of low-power setup enables gyro cycling, reset value zero.
// - low-power gyro averages two to the power of bits 6:4 samples.
// - in low-power gyro mode the normal gyro filter setting is ignored.
// - wake rate code 0 is 0.24 Hz, doubling to 500 Hz at code 11.

package msc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_GYRO_SETUP = 8'h1b;
  localparam logic [7:0] ADDR_ACCEL_SETUP = 8'h1c;
  localparam logic [7:0] ADDR_ACCEL_FILTER_SETUP = 8'h1d;
  localparam logic [7:0] ADDR_LOW_POWER_SETUP = 8'h1e;

  // writable bit masks, reserved bits stay zero
  localparam logic [7:0] MASK_GYRO_SETUP = 8'hfb;
  localparam logic [7:0] MASK_ACCEL_SETUP = 8'hf8;
  localparam logic [7:0] MASK_ACCEL_FILTER_SETUP = 8'h3f;
  localparam logic [7:0] MASK_LOW_POWER_SETUP = 8'hff;

  // reset values, all fields start cleared
  localparam logic [7:0] RST_GYRO_SETUP = 8'h00;
  localparam logic [7:0] RST_ACCEL_SETUP = 8'h00;
  localparam logic [7:0] RST_ACCEL_FILTER_SETUP = 8'h00;
  localparam logic [7:0] RST_LOW_POWER_SETUP = 8'h00;

  // ==========================================================================
  // field positions
  localparam int SELFTEST_LSB = 5;
  localparam int RANGE_LSB = 3;
  localparam int GYRO_BYPASS_LSB = 0;
  localparam int ACCEL_AVG_LSB = 4;
  localparam int ACCEL_BYPASS_BIT = 3;
  localparam int ACCEL_FILT_LSB = 0;
  localparam int GYRO_CYCLE_BIT = 7;
  localparam int GYRO_AVG_LSB = 4;
  localparam int WAKE_LSB = 0;

  // highest legal wake code, 500 Hz
  localparam logic [3:0] WAKE_CODE_MAX = 4'hb;

  // ==========================================================================
  // timing: clock rate and base tick rates
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned RATE_32K_HZ = 32_000;
  localparam int unsigned RATE_8K_HZ = 8_000;
  localparam int unsigned RATE_4K_HZ = 4_000;
  localparam int unsigned RATE_1K_HZ = 1_000;
  localparam int unsigned RATE_WAKE_HZ = 500;
  localparam int unsigned CYC_32K = CLK_HZ / RATE_32K_HZ;
  localparam int unsigned CYC_8K = CLK_HZ / RATE_8K_HZ;
  localparam int unsigned CYC_4K = CLK_HZ / RATE_4K_HZ;
  localparam int unsigned CYC_1K = CLK_HZ / RATE_1K_HZ;
  localparam int unsigned CYC_WAKE = CLK_HZ / RATE_WAKE_HZ;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {
    GP_BYPASS_WIDE = 2'b00,
    GP_BYPASS_NARROW = 2'b01,
    GP_FILTER = 2'b10,
    GP_LP_AVERAGE = 2'b11
  } msc_gyro_path_t;

  typedef enum logic [1:0] {
    RS_32K = 2'b00,
    RS_8K = 2'b01,
    RS_4K = 2'b10,
    RS_1K = 2'b11
  } msc_rate_sel_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [2:0] selftest;        // x, y, z from msb down
    logic [1:0] range;
    msc_gyro_path_t path;
    msc_rate_sel_t rate;
    logic [2:0] filter_setting;  // 3'h0 when not filtering
    logic lp_cycle;
    logic [7:0] avg_samples;
  } msc_gyro_cfg_t;

  typedef struct packed {
    logic [2:0] selftest;
    logic [1:0] range;
    logic bypass;
    msc_rate_sel_t rate;
    logic [2:0] filter_setting;
    logic [5:0] lp_avg_samples;
    logic [3:0] wake_code;
    logic wake_valid;
  } msc_accel_cfg_t;

endpackage : msc_pkg

// ---- hdl/msc_rate_div.sv ----
// tick divider: one strobe per (1 + divide) input ticks
// assumes tick is a one-cycle pulse on clk_sys; divide may change at any time
`timescale 1ns/1ps

module msc_rate_div #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // tick in and divisor
  input wire logic tick,
  input wire logic [W-1:0] divide,
  // divided strobe
  output logic strobe_ff
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic nxt_strobe;

  // >= rather than == so a smaller divisor never strands the count
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_strobe = 1'b0;
    if (tick) begin
      if (cnt_ff >= divide) begin
        nxt_cnt = '0;
        nxt_strobe = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_ff <= '0;
      strobe_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      strobe_ff <= nxt_strobe;
    end
  end

endmodule : msc_rate_div

// ---- hdl/msc_tick_gen.sv ----
// fixed-period tick generator: one-cycle enable every PERIOD clocks
// assumes PERIOD of at least 1, counts on clk_sys only
`timescale 1ns/1ps

module msc_tick_gen #(
  parameter int unsigned PERIOD = 250_000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // enable pulse
  output logic tick_ff
);

  localparam int W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic nxt_tick;

  // wrap at the period end and flag it
  always_comb begin
    nxt_tick = (cnt_ff == LAST);
    nxt_cnt = nxt_tick ? '0 : cnt_ff + W'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

endmodule : msc_tick_gen

// ---- test/msc_host_model.sv ----
// host model: single-byte writes and reads on the register port
// assumes one caller at a time; changes land at the falling edge
`timescale 1ns/1ps

module msc_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rdata_valid_ff
);
  // idle port from time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // ==========================================================================
  // one transfer; values pass unchanged so refused codes can be exercised
  task automatic xfer(input logic wr, input logic rd, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    reg_wr_en = wr;
    reg_rd_en = rd;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = ~d;  // stale data scrambled, nothing may rely on it
    q = reg_rdata_valid_ff ? reg_rdata_ff : 8'hxx;
  endtask : xfer
endmodule : msc_host_model

// ---- test/msc_meas_config_properties.sv ----
// checker for the measurement configuration block, bound to its top-level ports
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps

module msc_meas_config_properties #(
  parameter int unsigned CYC_32K = 4,
  parameter int unsigned CYC_8K = 8,
  parameter int unsigned CYC_4K = 16,
  parameter int unsigned CYC_1K = 32,
  parameter int unsigned CYC_WAKE = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rdata_valid_ff,
  // decoded configuration and wake strobe
  input wire msc_pkg::msc_gyro_cfg_t gyro_cfg_ff,
  input wire msc_pkg::msc_accel_cfg_t accel_cfg_ff,
  input wire logic accel_wake_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ==========================================================================
  // register port
  AST_RD_ANSWER: assert property (reg_rd_en |=> reg_rdata_valid_ff)
    else $error("read not answered");
  AST_RD_QUIET: assert property (!reg_rd_en |=> !reg_rdata_valid_ff
    && reg_rdata_ff == 8'h00)
    else $error("read data without a read");
  AST_RSVD_GYRO: assert property (reg_rd_en && reg_addr == 8'h1b |=> !reg_rdata_ff[2])
    else $error("gyro reserved bit reads one");
  AST_RSVD_FILT: assert property (reg_rd_en && reg_addr == 8'h1d |=>
    reg_rdata_ff[7:6] == 2'h0)
    else $error("filter reserved bits read one");
  AST_UNMAPPED: assert property (reg_rd_en && !(reg_addr inside {[8'h1b:8'h1e]})
    |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");

  // ==========================================================================
  // decoded configuration, two edges after the write lands
  AST_GYRO_FIELDS: assert property (reg_wr_en && reg_addr == 8'h1b |-> ##2
    {3'h0, gyro_cfg_ff.selftest, gyro_cfg_ff.range} == ($past(reg_wdata, 2) >> 3))
    else $error("gyro range or self-test not taken");
  AST_ACCEL_FIELDS: assert property (reg_wr_en && reg_addr == 8'h1c |-> ##2
    {3'h0, accel_cfg_ff.selftest, accel_cfg_ff.range} == ($past(reg_wdata, 2) >> 3))
    else $error("accel range or self-test not taken");
  // the reset cycle itself shows all-zero carriers, so the first edge is skipped
  AST_ACCEL_RATE: assert property (!$past(reset) |-> accel_cfg_ff.rate ==
    (accel_cfg_ff.bypass ? msc_pkg::RS_4K : msc_pkg::RS_1K))
    else $error("accel rate wrong for bypass");
  AST_WAKE_VALID: assert property (!$past(reset) |->
    accel_cfg_ff.wake_valid == (accel_cfg_ff.wake_code <= 4'hb))
    else $error("wake validity wrong");
  AST_WAKE_STOP: assert property (!accel_cfg_ff.wake_valid [*3] |-> !accel_wake_ff)
    else $error("wake strobe on reserved code");
  AST_LP_PATH: assert property (gyro_cfg_ff.path == msc_pkg::GP_LP_AVERAGE |->
    gyro_cfg_ff.lp_cycle && gyro_cfg_ff.filter_setting == 3'h0)
    else $error("low-power gyro uses filter setting");
  AST_BYPASS_32K: assert property (gyro_cfg_ff.path inside {msc_pkg::GP_BYPASS_WIDE,
    msc_pkg::GP_BYPASS_NARROW} |-> gyro_cfg_ff.rate == msc_pkg::RS_32K)
    else $error("gyro bypass not at 32k");

  // ==========================================================================
  // main scenarios reached
  COV_READ: cover property (reg_rd_en ##1 reg_rdata_valid_ff);
  COV_WAKE: cover property (accel_wake_ff);
  COV_LP: cover property (gyro_cfg_ff.path == msc_pkg::GP_LP_AVERAGE);
endmodule : msc_meas_config_properties

bind msc_meas_config msc_meas_config_properties #(.CYC_32K(CYC_32K), .CYC_8K(CYC_8K),
  .CYC_4K(CYC_4K), .CYC_1K(CYC_1K), .CYC_WAKE(CYC_WAKE)) u_msc_meas_config_properties (
  .clk_sys(clk_sys), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
  .reg_rdata_valid_ff(reg_rdata_valid_ff), .gyro_cfg_ff(gyro_cfg_ff),
  .accel_cfg_ff(accel_cfg_ff), .accel_wake_ff(accel_wake_ff));

// ---- test/tb.sv ----
// bench top: reset values, random and corner register traffic, rate strobes
// assumes the host model drives the port and the checker is bound in
`timescale 1ns/1ps

module tb;
  // ==========================================================================
  // shortened tick periods
  localparam int C32 = 4;
  localparam int C1 = 32;
  localparam int C4 = 16;
  localparam int CW = 8;
  localparam logic [7:0] MSK [4] = '{msc_pkg::MASK_GYRO_SETUP, msc_pkg::MASK_ACCEL_SETUP,
    msc_pkg::MASK_ACCEL_FILTER_SETUP, msc_pkg::MASK_LOW_POWER_SETUP};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic reg_wr_en, reg_rd_en, reg_rdata_valid_ff, gyro_odr_ff, accel_odr_ff, accel_wake_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, q, d;
  logic [7:0] rate_divider = 8'h00;
  logic [2:0] gyro_filter_setting = 3'h0;
  logic [7:0] r [4];  // shadow of the setup registers
  msc_pkg::msc_gyro_cfg_t gyro_cfg_ff;
  msc_pkg::msc_accel_cfg_t accel_cfg_ff;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 32'h72f6;
  int n;

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  msc_meas_config #(.CYC_32K(C32), .CYC_8K(8), .CYC_4K(C4), .CYC_1K(C1), .CYC_WAKE(CW))
    u_msc_meas_config (.clk_sys(clk_sys), .reset(reset), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_rdata_valid_ff(reg_rdata_valid_ff),
    .rate_divider(rate_divider), .gyro_filter_setting(gyro_filter_setting),
    .gyro_cfg_ff(gyro_cfg_ff), .accel_cfg_ff(accel_cfg_ff), .gyro_odr_ff(gyro_odr_ff),
    .accel_odr_ff(accel_odr_ff), .accel_wake_ff(accel_wake_ff));

  msc_host_model u_msc_host_model (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .reg_rdata_valid_ff(reg_rdata_valid_ff));

  // ==========================================================================
  // comparison and verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // expected decode; bypass wins over low-power cycling
  function automatic msc_pkg::msc_gyro_cfg_t exp_gyro(logic [7:0] g, logic [7:0] l,
      logic [2:0] fs);
    msc_pkg::msc_gyro_cfg_t e;
    e.selftest = g[7:5];
    e.range = g[4:3];
    e.path = g[0] ? msc_pkg::GP_BYPASS_WIDE : g[1] ? msc_pkg::GP_BYPASS_NARROW :
      l[7] ? msc_pkg::GP_LP_AVERAGE : msc_pkg::GP_FILTER;
    e.rate = (e.path == msc_pkg::GP_FILTER && (fs == 3'h0 || fs == 3'h7)) ? msc_pkg::RS_8K :
      e.path[1] ? msc_pkg::RS_1K : msc_pkg::RS_32K;
    e.filter_setting = (e.path == msc_pkg::GP_FILTER) ? fs : 3'h0;
    e.lp_cycle = l[7];
    e.avg_samples = 8'h01 << l[6:4];
    return e;
  endfunction : exp_gyro

  function automatic msc_pkg::msc_accel_cfg_t exp_accel(logic [7:0] a, logic [7:0] f,
      logic [7:0] l);
    msc_pkg::msc_accel_cfg_t e;
    e.selftest = a[7:5];
    e.range = a[4:3];
    e.bypass = f[3];
    e.rate = f[3] ? msc_pkg::RS_4K : msc_pkg::RS_1K;
    e.filter_setting = f[3] ? 3'h0 : f[2:0];
    e.lp_avg_samples = 6'h04 << f[5:4];
    e.wake_code = l[3:0];
    e.wake_valid = l[3:0] <= 4'hb;
    return e;
  endfunction : exp_accel

  function automatic logic stb(int s);
    return (s == 0) ? gyro_odr_ff : (s == 1) ? accel_odr_ff : accel_wake_ff;
  endfunction : stb

  // ==========================================================================
  // bus helpers and strobe spacing; third gap is used so divider changes settle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_msc_host_model.xfer(1'b1, 1'b0, a, v, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_msc_host_model.xfer(1'b0, 1'b1, a, 8'h00, q);
    check("read data", q, e);
  endtask : rd_chk

  task automatic period(input int s, output int p);
    int c;
    p = -1;
    for (int k = 0; k < 3; k++) begin
      c = 0;
      do begin
        @(negedge clk_sys);
        c++;
      end while (stb(s) !== 1'b1 && c < 3000);
      if (stb(s) !== 1'b1) begin
        p = -1;
        return;
      end
      p = c;
    end
  endtask : period

  // hang guard
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      r[i] = 8'h00;
      rd_chk(8'(8'h1b + i), 8'h00);
    end
    wr(8'h1f, 8'hff);
    rd_chk(8'h1f, 8'h00);
    rd_chk(8'h1a, 8'h00);
    // all ones, all zeros, then random settings
    for (int k = 0; k < 26; k++) begin
      for (int i = 0; i < 4; i++) begin
        d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
        wr(8'(8'h1b + i), d);
        r[i] = d & MSK[i];
      end
      gyro_filter_setting = 3'($random(seed));
      rate_divider = 8'($random(seed));
      for (int i = 0; i < 4; i++) begin
        rd_chk(8'(8'h1b + i), r[i]);
      end
      repeat (2) @(negedge clk_sys);
      check("gyro cfg", gyro_cfg_ff,
        exp_gyro(r[0], r[3], gyro_filter_setting));
      check("accel cfg", accel_cfg_ff,
        exp_accel(r[1], r[2], r[3]));
    end
    // write and read in one cycle: read sees the old value
    u_msc_host_model.xfer(1'b1, 1'b1, 8'h1c, 8'h5a, q);
    check("same-cycle read", q, r[1]);
    rd_chk(8'h1c, 8'h58);
    // strobe spacing through the divider
    wr(8'h1b, 8'h00);
    wr(8'h1e, 8'h0b);
    wr(8'h1d, 8'h00);
    gyro_filter_setting = 3'h1;
    for (int dv = 0; dv < 3; dv += 2) begin
      rate_divider = 8'(dv);
      period(0, n);
      check("gyro period", n, C1 * (1 + dv));
      period(1, n);
      check("accel period", n, C1 * (1 + dv));
    end
    // filter setting 7 runs at 8 kHz, where the divider does not apply
    gyro_filter_setting = 3'h7;
    period(0, n);
    check("gyro 8k period", n, 8);
    wr(8'h1d, 8'h08);
    period(1, n);
    check("accel bypass period", n, C4);
    wr(8'h1b, 8'h01);
    period(0, n);
    check("gyro bypass period", n, C32);
    wr(8'h1b, 8'h00);
    wr(8'h1e, 8'h89);
    period(0, n);
    check("gyro lp period", n, C1 * 3);
    period(2, n);
    check("wake period", n, CW * 4);
    wr(8'h1e, 8'h0b);
    period(2, n);
    check("wake fast period", n, CW);
    wr(8'h1e, 8'h0c);
    period(2, n);
    check("wake reserved", n, -1);
    print_verdict();
  end
endmodule : tb
